// File: inc/psc_params.svh
// Constants for the pipeline select and cache control block
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH
// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define PSC_ADDR_CMD        12'h000
`define PSC_ADDR_STATUS     12'h004
`define PSC_ADDR_CTX        12'h008
`define PSC_ADDR_MOCS       12'h00c
`define PSC_ADDR_MOCS_RES   12'h010
`define PSC_ADDR_FUNC       12'h014
`define PSC_ADDR_FUNC_RES   12'h018
`define PSC_ADDR_SCRATCH    12'h01c
// ----------------------------------------------------------------------------
// Command dword fields
// ----------------------------------------------------------------------------
`define PSC_CMD_TYPE        3'h3
`define PSC_CMD_SUBTYPE     2'h1
`define PSC_CMD_OPCODE      3'h1
`define PSC_CMD_SUBOP_SEL   8'h04
`define PSC_CMD_SUBOP_BASE  8'h01
`define PSC_MBZ_ZERO        14'h0000
// ----------------------------------------------------------------------------
// Pipeline codes and function ids
// ----------------------------------------------------------------------------
`define PSC_PIPE_3D         2'h0
`define PSC_PIPE_MEDIA      2'h1
`define PSC_PIPE_GPGPU      2'h2
`define PSC_PIPE_RSVD       2'h3
`define PSC_ID_SPAWNER      4'h7
`define PSC_ID_WINDOWER     4'hf
// ----------------------------------------------------------------------------
// Scratch sizing configurations
// ----------------------------------------------------------------------------
`define PSC_EU_BIG          8'h10
`define PSC_THR_BIG         8'h08
`define PSC_EU_SMALL        8'h06
`define PSC_THR_SMALL       8'h06
`define PSC_N_STAGES        4
`endif

// File: inc/psc_pkg.sv
// Types for the pipeline select and cache control block
package psc_pkg;
  typedef enum logic [1:0] {
    PSC_IDLE  = 2'b00,
    PSC_DRAIN = 2'b01,
    PSC_FREE  = 2'b10,
    PSC_FENCE = 2'b11
  } psc_state_e;
endpackage : psc_pkg

// File: core/psc_func_decode.sv
// Shared and fixed function identifier decoder
`timescale 1ns/100ps
`include "psc_params.svh"
module psc_func_decode (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] id_in,
  output logic      [3:0] shared_func_q,
  output logic      [3:0] fixed_func_q,
  output logic            shared_res_q,
  output logic            fixed_res_q
);
  // ------------------------------------------------------------------------
  // Registered one-hot-free lookup of both tables
  // ------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_func_q <= 4'h0;
      fixed_func_q  <= 4'h0;
      shared_res_q  <= 1'b0;
      fixed_res_q   <= 1'b0;
    end else begin
      shared_func_q <= id_in;
      fixed_func_q  <= id_in;
      // Shared codes 1 and C..F are reserved
      shared_res_q  <= (id_in == 4'h1) || (id_in > 4'hb);   // see R12
      // Fixed codes 1,2,3,6 are reserved; spawner shares 7 in both
      fixed_res_q   <= (id_in == 4'h1) || (id_in == 4'h2) || (id_in == 4'h3) || (id_in == 4'h6);   // see R13 R14
    end
  end
endmodule : psc_func_decode

// File: core/psc_core.sv
// Pipeline select sequencer, cache control decode and APB registers
`timescale 1ns/100ps
`include "psc_params.svh"
//
// Function
// R1: Forward commands only to active pipeline
// R2: Own return buffer allocation and constant entry
// R3: Select command is one fixed dword
// R4: Select field 0 3D, 1 media, 2 compute
// R5: Reserved select leaves pipe unchanged
// R6: Source avoids wrong-pipe commands
// R7: Pipe change flushes the old pipe
// R8: Stages free only after tasks finish
// R9: Windower frees constant entry, then fences set
// R10: Source flushes before select command
// R11: Selected pipe kept in context state
// R12: Shared function codes decoded, others reserved
// R13: Fixed function codes decoded, others reserved
// R14: Spawner uses code seven in both
// R15: Scratch scales with units times threads
// R16: Object classes take base-address cache control
// R17: Write tag is structure bit OR table
// R18: Tag stored with last-level cache lines
// R19: Bit one forces last-level cacheable
// R20: Bit zero controls level-3 allocation
// R21: Level-3 non-allocating stays coherent
// R22: Base-address command forces full flush
module psc_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmd_valid,
  input  wire logic [31:0] cmd_data,
  output logic             cmd_ready,
  output logic             pipe3d_valid,
  output logic             pipemedia_valid,
  output logic      [31:0] pipe_cmd_q,
  output logic      [1:0]  active_pipe_q,
  output logic             dealloc_flush_q,
  input  wire logic [3:0]  stage_idle,
  output logic      [3:0]  stage_free_q,
  output logic             const_entry_release_q,
  input  wire logic        entries_freed,
  output logic             fence_program_q,
  output logic      [1:0]  fence_pipe_q,
  output logic             full_flush_q,
  input  wire logic        full_flush_done,
  input  wire logic        mem_write,
  input  wire logic        tt_display_tag,
  input  wire logic        tt_cacheable,
  input  wire logic [1:0]  obj_class,
  output logic             eff_display_tag,
  output logic             llc_cacheable,
  output logic             l3_allocate,
  output logic             l3_coherent
);
  // ------------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------------
  psc_pkg::psc_state_e state_q;
  logic        sel_hit;
  logic        base_hit;
  logic        busy;
  logic        wr_en;
  logic        rd_en;
  logic [1:0]  old_pipe_q;
  logic [1:0]  new_pipe_q;
  logic [3:0]  stage_done_q;
  logic [11:0] mocs_class_q;
  logic [2:0]  mocs_sel;
  logic [3:0]  id_q;
  logic        scratch_small_q;
  logic [3:0]  sh_func;
  logic [3:0]  fx_func;
  logic        sh_res;
  logic        fx_res;
  logic [15:0] scratch_slots;
  logic [31:0] rdata_d;
  logic        cmd_is_pipe;

  // ------------------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------------------
  // Select dword: type, subtype, opcode, sub-opcode and zero reserved bits
  assign sel_hit  = (cmd_data[31:29] == `PSC_CMD_TYPE) && (cmd_data[28:27] == `PSC_CMD_SUBTYPE)
                 && (cmd_data[26:24] == `PSC_CMD_OPCODE) && (cmd_data[23:16] == `PSC_CMD_SUBOP_SEL)
                 && (cmd_data[15:2] == `PSC_MBZ_ZERO);   // see R3
  assign base_hit = (cmd_data[31:29] == `PSC_CMD_TYPE) && (cmd_data[28:16] ==
                    {2'h0, `PSC_CMD_OPCODE, `PSC_CMD_SUBOP_BASE});
  assign busy        = (state_q != psc_pkg::PSC_IDLE) || full_flush_q;
  assign cmd_ready   = !busy;
  assign cmd_is_pipe = cmd_valid && cmd_ready && !sel_hit && !base_hit;
  // Forward only to the active pipe; compute work rides the media pipe
  assign pipe3d_valid    = cmd_is_pipe && (active_pipe_q == `PSC_PIPE_3D);   // see R1
  assign pipemedia_valid = cmd_is_pipe && (active_pipe_q != `PSC_PIPE_3D);   // see R1

  // Registered copy of the forwarded dword
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe_cmd_q <= 32'h0000_0000;
    end else if (cmd_is_pipe) begin
      pipe_cmd_q <= cmd_data;
    end
  end

  // ------------------------------------------------------------------------
  // Pipeline switch sequencer
  // ------------------------------------------------------------------------
  // IDLE takes a select; DRAIN waits per stage; FREE waits for all entries;
  // FENCE programs the new pipe's return-buffer fences.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= psc_pkg::PSC_IDLE;
      old_pipe_q <= `PSC_PIPE_3D;
      new_pipe_q <= `PSC_PIPE_3D;
    end else begin
      case (state_q)
        psc_pkg::PSC_IDLE: begin
          if (cmd_valid && cmd_ready && sel_hit && (cmd_data[1:0] != `PSC_PIPE_RSVD)   // see R5
              && (cmd_data[1:0] != active_pipe_q)) begin   // see R4
            old_pipe_q <= active_pipe_q;
            new_pipe_q <= cmd_data[1:0];
            state_q    <= psc_pkg::PSC_DRAIN;   // see R7
          end
        end
        psc_pkg::PSC_DRAIN: begin
          if (&stage_done_q) begin
            state_q <= psc_pkg::PSC_FREE;
          end
        end
        psc_pkg::PSC_FREE: begin
          if (entries_freed) begin
            state_q <= psc_pkg::PSC_FENCE;   // see R9
          end
        end
        psc_pkg::PSC_FENCE: begin
          state_q <= psc_pkg::PSC_IDLE;
        end
        default: begin
          state_q <= psc_pkg::PSC_IDLE;
        end
      endcase
    end
  end

  // Deallocating flush pulse down the old pipe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dealloc_flush_q <= 1'b0;
    end else begin
      dealloc_flush_q <= (state_q == psc_pkg::PSC_IDLE) && cmd_valid && cmd_ready && sel_hit
                      && (cmd_data[1:0] != `PSC_PIPE_RSVD) && (cmd_data[1:0] != active_pipe_q);   // see R7
    end
  end

  // Per-stage free strobe once that stage has no tasks in flight
  genvar gi;
  generate
    for (gi = 0; gi < `PSC_N_STAGES; gi = gi + 1) begin : g_stage
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage_done_q[gi] <= 1'b0;
          stage_free_q[gi] <= 1'b0;
        end else if (state_q != psc_pkg::PSC_DRAIN) begin
          stage_done_q[gi] <= 1'b0;
          stage_free_q[gi] <= 1'b0;
        end else begin
          stage_free_q[gi] <= !stage_done_q[gi] && stage_idle[gi];   // see R8
          if (stage_idle[gi]) begin
            stage_done_q[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Constant entry release, fence programming and active pipe update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      const_entry_release_q <= 1'b0;
      fence_program_q       <= 1'b0;
      fence_pipe_q          <= `PSC_PIPE_3D;
      active_pipe_q         <= `PSC_PIPE_3D;
    end else begin
      const_entry_release_q <= (state_q == psc_pkg::PSC_DRAIN) && (&stage_done_q);   // see R9 R2
      fence_program_q       <= (state_q == psc_pkg::PSC_FENCE);   // see R2
      if (state_q == psc_pkg::PSC_FENCE) begin
        fence_pipe_q  <= new_pipe_q;
        active_pipe_q <= new_pipe_q;
      end else if (wr_en && (paddr == `PSC_ADDR_CTX) && !busy
                   && (pwdata[1:0] != `PSC_PIPE_RSVD)) begin
        active_pipe_q <= pwdata[1:0];   // see R11
      end
    end
  end

  // Full flush on the base-address command, held until the pipes report done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_flush_q <= 1'b0;
    end else if (cmd_valid && cmd_ready && base_hit) begin
      full_flush_q <= 1'b1;   // see R22
    end else if (full_flush_done) begin
      full_flush_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------------
  // Memory object cache control
  // ------------------------------------------------------------------------
  // Objects without own surface state use the per-class field
  assign mocs_sel        = mocs_class_q[obj_class*3 +: 3];   // see R16
  assign eff_display_tag = mem_write && (mocs_sel[2] || tt_display_tag);   // see R17 R18
  assign llc_cacheable   = mocs_sel[1] ? 1'b1 : tt_cacheable;   // see R19
  assign l3_allocate     = mocs_sel[0];   // see R20
  assign l3_coherent     = 1'b1;   // see R21

  // ------------------------------------------------------------------------
  // Function id decode
  // ------------------------------------------------------------------------
  psc_func_decode u_func (
    .pclk          (pclk),
    .presetn       (presetn),
    .id_in         (id_q),
    .shared_func_q (sh_func),
    .fixed_func_q  (fx_func),
    .shared_res_q  (sh_res),
    .fixed_res_q   (fx_res)
  );   // see R12 R13 R14

  // Scratch slots = units times threads for the chosen configuration
  assign scratch_slots = scratch_small_q ? (16'(`PSC_EU_SMALL) * 16'(`PSC_THR_SMALL))
                                         : (16'(`PSC_EU_BIG) * 16'(`PSC_THR_BIG));   // see R15

  // ------------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------------
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign pslverr = 1'b0;

  // Writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mocs_class_q    <= 12'h000;
      id_q            <= 4'h0;
      scratch_small_q <= 1'b0;
    end else if (wr_en) begin
      if (paddr == `PSC_ADDR_MOCS) begin
        mocs_class_q <= pwdata[11:0];
      end
      if (paddr == `PSC_ADDR_FUNC) begin
        id_q <= pwdata[3:0];
      end
      if (paddr == `PSC_ADDR_SCRATCH) begin
        scratch_small_q <= pwdata[16];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `PSC_ADDR_STATUS:   rdata_d = {24'h0, full_flush_q, 1'b0, state_q, old_pipe_q, active_pipe_q};
      `PSC_ADDR_CTX:      rdata_d = {30'h0, active_pipe_q};
      `PSC_ADDR_MOCS:     rdata_d = {20'h0, mocs_class_q};
      `PSC_ADDR_MOCS_RES: rdata_d = {29'h0, eff_display_tag, llc_cacheable, l3_allocate};
      `PSC_ADDR_FUNC:     rdata_d = {28'h0, id_q};
      `PSC_ADDR_FUNC_RES: rdata_d = {22'h0, sh_res, fx_res, fx_func, sh_func};
      `PSC_ADDR_SCRATCH:  rdata_d = {15'h0, scratch_small_q, scratch_slots};
      default:            rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rdata_d;
    end
  end
endmodule : psc_core

// File: tb/psc_core_sva.sv
// Checker on the ports of the pipeline select core
`timescale 1ns/100ps
module psc_core_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        cmd_valid,
  input wire logic [31:0] cmd_data,
  input wire logic        cmd_ready,
  input wire logic        pipe3d_valid,
  input wire logic        pipemedia_valid,
  input wire logic [1:0]  active_pipe_q,
  input wire logic        dealloc_flush_q,
  input wire logic [3:0]  stage_idle,
  input wire logic [3:0]  stage_free_q,
  input wire logic        const_entry_release_q,
  input wire logic        fence_program_q,
  input wire logic [1:0]  fence_pipe_q,
  input wire logic        full_flush_q,
  input wire logic        mem_write,
  input wire logic        tt_display_tag,
  input wire logic        eff_display_tag
);
  logic       take, is_sel, is_base, rel_q;
  logic [3:0] freed_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted command dword decode
  assign take    = cmd_valid && cmd_ready;
  assign is_sel  = take && cmd_data[31:16] == 16'h6904 && cmd_data[15:2] == 14'h0000;
  assign is_base = take && cmd_data[31:16] == 16'h6101;
  // Stages freed since the last flush and constant entry released since the last fence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freed_q <= 4'h0;
      rel_q   <= 1'b0;
    end else begin
      freed_q <= (dealloc_flush_q ? 4'h0 : freed_q) | stage_free_q;
      rel_q   <= fence_program_q ? 1'b0 : (rel_q | const_entry_release_q);
    end
  end
  sequence s_switch;
    is_sel && cmd_data[1:0] != active_pipe_q && cmd_data[1:0] != 2'h3;
  endsequence
  sequence s_dealloc;
    dealloc_flush_q ##[1:400] fence_program_q;
  endsequence
  property p_fwd_3d;
    pipe3d_valid |-> take && active_pipe_q == 2'h0 && !pipemedia_valid;
  endproperty
  property p_fwd_media;
    pipemedia_valid |-> take && active_pipe_q != 2'h0;
  endproperty
  property p_sel_held;
    is_sel |-> !pipe3d_valid && !pipemedia_valid;
  endproperty
  property p_switch;
    s_switch |=> s_dealloc;
  endproperty
  property p_noop;
    is_sel && (cmd_data[1:0] == active_pipe_q || cmd_data[1:0] == 2'h3) |=> !dealloc_flush_q && $stable(active_pipe_q);
  endproperty
  property p_stage_free;
    (stage_free_q & ~$past(stage_idle)) == 4'h0;
  endproperty
  property p_const_rel;
    const_entry_release_q |-> (freed_q | stage_free_q) == 4'hf;
  endproperty
  property p_fence;
    fence_program_q |-> rel_q && fence_pipe_q == active_pipe_q;
  endproperty
  property p_base;
    is_base |=> full_flush_q;
  endproperty
  property p_flush_block;
    full_flush_q |-> !cmd_ready;
  endproperty
  property p_tag;
    (!mem_write |-> !eff_display_tag) and (mem_write && tt_display_tag |-> eff_display_tag);
  endproperty
  a_fwd_3d: assert property (p_fwd_3d) else $error("3d strobe off pipe");
  a_fwd_media: assert property (p_fwd_media) else $error("media strobe off pipe");
  a_sel_held: assert property (p_sel_held) else $error("select forwarded");
  a_switch: assert property (p_switch) else $error("no flush walk");
  a_noop: assert property (p_noop) else $error("noop select acted");
  a_stage_free: assert property (p_stage_free) else $error("busy stage freed");
  a_const_rel: assert property (p_const_rel) else $error("early entry release");
  a_fence: assert property (p_fence) else $error("bad fence");
  a_base: assert property (p_base) else $error("no full flush");
  a_flush_block: assert property (p_flush_block) else $error("ready in flush");
  a_tag: assert property (p_tag) else $error("bad display tag");
endmodule : psc_core_sva
bind psc_core psc_core_sva i_sva (.*);

// File: tb/psc_pipe_model.sv
// Model of the old-pipe stages and the memory side
`timescale 1ns/100ps
module psc_pipe_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       slow,
  input  wire logic       pipe3d_valid,
  input  wire logic       pipemedia_valid,
  input  wire logic       const_entry_release_q,
  input  wire logic       fence_program_q,
  input  wire logic       full_flush_q,
  output logic      [3:0] stage_idle,
  output logic            entries_freed,
  output logic            full_flush_done
);
  logic [3:0] busy_q [4];
  logic [3:0] cnt_q;
  // Work in flight per stage after each forwarded dword, deeper stages last longer
  always_ff @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 4; i++) begin
      if (!presetn) busy_q[i] <= 4'h0;
      else if (pipe3d_valid || pipemedia_valid) busy_q[i] <= 4'(i + (slow ? 8 : 1));
      else if (busy_q[i] != 4'h0) busy_q[i] <= busy_q[i] - 4'h1;
    end
  end
  assign stage_idle = {busy_q[3] == 4'h0, busy_q[2] == 4'h0, busy_q[1] == 4'h0, busy_q[0] == 4'h0};
  // Entries drain after the constant entry goes; a full flush ends after a delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q           <= 4'h0;
      entries_freed   <= 1'b0;
      full_flush_done <= 1'b0;
    end else begin
      if (const_entry_release_q || (full_flush_q && cnt_q == 4'h0 && !full_flush_done)) cnt_q <= slow ? 4'h9 : 4'h2;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
      entries_freed   <= (entries_freed || (cnt_q == 4'h1 && !full_flush_q)) && !fence_program_q;
      full_flush_done <= full_flush_q && (full_flush_done || cnt_q == 4'h1);
    end
  end
endmodule : psc_pipe_model

// File: tb/tb_top.sv
// Self-checking bench for the pipeline select core
`timescale 1ns/100ps
`include "psc_params.svh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cmd_valid, cmd_ready, slow;
  logic        pipe3d_valid, pipemedia_valid, dealloc_flush_q, const_entry_release_q, entries_freed;
  logic        fence_program_q, full_flush_q, full_flush_done, mem_write, tt_display_tag, tt_cacheable;
  logic        eff_display_tag, llc_cacheable, l3_allocate, l3_coherent;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cmd_data, pipe_cmd_q, r;
  logic [1:0]  active_pipe_q, fence_pipe_q, obj_class, exp_pipe, f;
  logic [3:0]  stage_idle, stage_free_q;
  logic [15:0] seed;
  logic [63:0] rd_q[$], e;
  logic [33:0] fw_q[$], w;
  logic [31:0] exp_cmd = 32'h0000_0000;
  logic [1:0]  fc_q[$];
  logic [2:0]  mf;
  int          n_mismatch, check_count;
  psc_core       i_dut (.*);
  psc_pipe_model i_model (.*);
  // Free-running clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++) seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return {seed, seed ^ 16'h5a5a};
  endfunction : rnd
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  // Wait for a settled ready, then let the taking edge pass
  task automatic wait_ack(input bit for_cmd);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((for_cmd ? cmd_ready : pready) !== 1'b1 && n < 400);
    if (n >= 400) begin
      n_mismatch++;
      results();
    end
    @(posedge pclk);
  endtask : wait_ack
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
    if (!wr) rd_q.push_back({m, d});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wait_ack(1'b0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic send(input logic [31:0] d);
    if (d[31:16] != 16'h6904 && d[31:16] != 16'h6101) fw_q.push_back({exp_pipe == 2'h0 ? 2'b01 : 2'b10, d});
    else if (d[31:16] == 16'h6904 && d[1:0] != 2'h3 && d[1:0] != exp_pipe) begin
      exp_pipe = d[1:0];
      fc_q.push_back(d[1:0]);
    end
    cmd_valid <= 1'b1;
    cmd_data  <= d;
    wait_ack(1'b1);
  endtask : send
  task automatic fwd(input int n);
    repeat (n) begin
      r = rnd();
      send({exp_pipe == 2'h0 ? 5'h1b : 5'h1c, r[26:0]});
    end
  endtask : fwd
  // Match each result against the oldest note of its kind
  always @(posedge pclk) begin
    if (presetn === 1'b1 && psel && penable && pready) begin
      chk("slave error", 34'h0, {33'h0, pslverr});
    end
    if (presetn === 1'b1 && psel && penable && !pwrite && pready) begin
      e = rd_q.size() > 0 ? rd_q.pop_front() : {32'hffff_ffff, 32'hx};
      chk("read data", e[31:0] & e[63:32], prdata & e[63:32]);
    end
    // Forwarded dword must stand in the copy register from the next edge on
    if (presetn === 1'b1) chk("pipe cmd", {2'h0, exp_cmd}, {2'h0, pipe_cmd_q});
    if (pipe3d_valid || pipemedia_valid) begin
      w = fw_q.size() > 0 ? fw_q.pop_front() : 34'hx;
      chk("forward", w, {pipemedia_valid, pipe3d_valid, cmd_data});
      exp_cmd <= w[31:0];
    end
    if (fence_program_q === 1'b1) begin
      f = fc_q.size() > 0 ? fc_q.pop_front() : 2'hx;
      chk("fence pipe", f, fence_pipe_q);
      chk("active pipe", f, active_pipe_q);
    end
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, cmd_valid, slow, mem_write, tt_display_tag, tt_cacheable} = 8'h00;
    {paddr, pwdata, cmd_data, obj_class} = 78'h0;
    presetn = 1'b0;
    seed = 16'h61a4;
    exp_pipe = 2'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("cmd ready", 1'b1, cmd_ready);
    chk("reset pipe", 2'h0, active_pipe_q);
    apb(1'b0, `PSC_ADDR_STATUS, 32'h0, 32'hffff_ffff);
    apb(1'b1, 12'h020, 32'hffff_ffff, 32'h0);
    apb(1'b0, 12'h020, 32'h0, 32'hffff_ffff);
    apb(1'b0, `PSC_ADDR_CMD, 32'h0, 32'hffff_ffff);
    apb(1'b1, `PSC_ADDR_SCRATCH, 32'h0001_0000, 32'h0);
    apb(1'b0, `PSC_ADDR_SCRATCH, 32'h0001_0024, 32'h0001_ffff);
    apb(1'b1, `PSC_ADDR_SCRATCH, 32'h0, 32'h0);
    apb(1'b0, `PSC_ADDR_SCRATCH, 32'h0000_0080, 32'h0001_ffff);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, `PSC_ADDR_FUNC, 32'(i), 32'h0);
      apb(1'b0, `PSC_ADDR_FUNC_RES, {22'h0, i == 1 || i > 11, i inside {1, 2, 3, 6}, 4'(i), 4'(i)}, 32'h3ff);
    end
    for (int k = 0; k < 16; k++) begin
      r = rnd();
      apb(1'b1, `PSC_ADDR_MOCS, {20'h0, r[11:0]}, 32'h0);
      {obj_class, mem_write, tt_display_tag, tt_cacheable} <= r[16:12];
      @(negedge pclk);
      mf = 3'(r[11:0] >> (3 * r[16:15]));
      chk("display tag", r[14] & (mf[2] | r[13]), eff_display_tag);
      chk("llc cacheable", mf[1] | r[12], llc_cacheable);
      chk("l3 allocate", mf[0], l3_allocate);
      chk("l3 coherent", 1'b1, l3_coherent);
      apb(1'b0, `PSC_ADDR_MOCS_RES, {29'h0, r[14] & (mf[2] | r[13]), mf[1] | r[12], mf[0]}, 32'h7);
    end
    @(posedge pclk);
    fwd(3);
    send(32'h0200_0000);
    send(32'h6904_0001);
    fwd(2);
    send(32'h6904_0001);
    send(32'h6904_0003);
    fwd(1);
    slow <= 1'b1;
    send(32'h6904_0002);
    fwd(2);
    send(32'h6904_0000);
    fwd(1);
    send(32'h6101_0008);
    fwd(2);
    cmd_valid <= 1'b0;
    apb(1'b0, `PSC_ADDR_CTX, 32'h0, 32'h3);
    apb(1'b1, `PSC_ADDR_CTX, 32'h1, 32'h0);
    apb(1'b1, `PSC_ADDR_CTX, 32'h3, 32'h0);
    apb(1'b0, `PSC_ADDR_CTX, 32'h1, 32'h3);
    @(negedge pclk);
    chk("restored pipe", 2'h1, active_pipe_q);
    exp_pipe = 2'h1;
    @(posedge pclk);
    fwd(1);
    cmd_valid <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("pending notes", 34'h0, 34'(rd_q.size() + fw_q.size() + fc_q.size()));
    results();
  end
endmodule : tb_top
